// ### mwcc_cfg.svh
// register indexes, field positions, reset values and constants of the wake and checksum control block
`ifndef MWCC_CFG_SVH
`define MWCC_CFG_SVH

// register indexes; byte address is index times four
`define MWCC_IDX_FILTER   8'h0b
`define MWCC_IDX_WAKE     8'h0c
`define MWCC_IDX_CSUM     8'h0d
`define MWCC_IDX_IRQ_STAT 8'h10
`define MWCC_IDX_IRQ_MASK 8'h11

// wake control and status fields
`define MWCC_WK_GUE       9
`define MWCC_WK_WFR       6
`define MWCC_WK_MPR       5
`define MWCC_WK_WEN       2
`define MWCC_WK_MPE       1
`define MWCC_WK_ALL_MASK  32'h0000_0266

// checksum offload control fields
`define MWCC_CS_TXEN      16
`define MWCC_CS_MODE      1
`define MWCC_CS_RXEN      0
`define MWCC_CS_ALL_MASK  32'h0001_0003

// interrupt status and mask fields
`define MWCC_IRQ_WFR      0
`define MWCC_IRQ_MPR      1
`define MWCC_IRQ_UNI      2
`define MWCC_IRQ_W        3

// reset values
`define MWCC_RST_WORD     32'h0000_0000
`define MWCC_RST_IRQ      3'h0

// checksum start offsets in bytes
`define MWCC_ETH_HDR_BYTES 8'h0e
`define MWCC_VLAN_BYTES    8'h04
`define MWCC_SNAP_BYTES    8'h08

// bus responses
`define MWCC_RESP_OKAY    2'h0
`define MWCC_RESP_SLVERR  2'h2

`endif

// ### mwcc_filter.sv
// wake frame filter store loaded through one indexed write port
`timescale 1ns/1ps
`default_nettype none
`include "mwcc_cfg.svh"

module mwcc_filter #(
    parameter int ENTRIES = 8,
    parameter int W       = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             soft_reset_i,
    // write port
    input  wire logic             wr_i,
    input  wire logic [W-1:0]     wdata_i,
    input  wire logic [3:0]       wstrb_i,
    // filter contents
    output var  logic [ENTRIES*W-1:0] entries_o
);
    import mwcc_pkg::*;

    localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

    if (W != 32 || ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0)
    begin : g_bad_param
        $error("mwcc_filter: W must be 32 and ENTRIES a power of two");
    end

    logic [W-1:0]  mem_r [ENTRIES];
    logic [PW-1:0] ptr_r;
    logic [W-1:0]  wm;

    assign wm = mwcc_strb_mask(wstrb_i);

    ////////////////////////////////////////////////////////////////////////////
    // index pointer, wraps after the last entry
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ptr_r <= '0;
        else if (soft_reset_i)
            ptr_r <= '0; // RL14
        else if (wr_i)
            ptr_r <= (ptr_r == PW'(ENTRIES - 1)) ? '0 : PW'(ptr_r + 1'b1); // RL14
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < ENTRIES; i++)
                mem_r[i] <= `MWCC_RST_WORD;
        end
        else if (wr_i)
            mem_r[ptr_r] <= (mem_r[ptr_r] & ~wm) | (wdata_i & wm); // RL14
    end

    always_comb
    begin
        entries_o = '0;
        for (int i = 0; i < ENTRIES; i++)
            entries_o[i*W +: W] = mem_r[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    filter_wrap_a : assert property (wr_i && !soft_reset_i && ptr_r == PW'(ENTRIES - 1) |=> ptr_r == '0) // RL14
        else $error("filter pointer did not wrap");
    filter_step_a : assert property (wr_i && !soft_reset_i && ptr_r != PW'(ENTRIES - 1) |=> ptr_r == $past(ptr_r) + 1'b1) // RL14
        else $error("filter pointer did not advance");

endmodule // mwcc_filter

`default_nettype wire

// ### mwcc_pkg.sv
// types and helper functions of the wake and checksum control block
`default_nettype none
`include "mwcc_cfg.svh"

package mwcc_pkg;

    // receive path event and parse information
    typedef struct packed {
        logic        frame_done;
        logic        frame_ok;
        logic [47:0] dest_addr;
        logic        wake_match;
        logic        magic_match;
        logic [1:0]  vlan_tags;
        logic        snap;
    } mwcc_rx_type;

    // checksum engine controls
    typedef struct packed {
        logic       tx_enable;
        logic       rx_enable;
        logic       rx_l3_mode;
        logic [7:0] rx_start_byte;
    } mwcc_csum_type;

    // wake detector enables
    typedef struct packed {
        logic global_unicast_wake_enable;
        logic wake_frame_enable;
        logic magic_packet_enable;
    } mwcc_wake_mode_type;

    typedef enum logic [1:0] {
        MWCC_WR_IDLE = 2'h1,
        MWCC_WR_RESP = 2'h2
    } mwcc_wr_state_type;

    // byte strobes to a bit mask
    function automatic logic [31:0] mwcc_strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            m[8*i +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    function automatic logic [29:0] mwcc_word_idx(input logic [31:0] a);
        return a[31:2];
    endfunction

    // layer-3 start behind vlan tags and snap header
    function automatic logic [7:0] mwcc_l3_start(input logic [1:0] tags, input logic snap);
        logic [7:0] v;
        v = `MWCC_ETH_HDR_BYTES;
        v = 8'(v + 8'(tags) * `MWCC_VLAN_BYTES);
        if (snap)
        begin
            v = 8'(v + `MWCC_SNAP_BYTES);
        end
        return v;
    endfunction

endpackage

`default_nettype wire

// ### mwcc_top.sv
// wake-up control and checksum offload control registers with AXI4-Lite access
//
// Contract
// RL1 - global unicast wake enabled: a global unicast frame wakes the device from power save
// RL2 - a frame is global unicast when destination address bit 0 is zero
// RL3 - a valid wake-up frame sets the wake-frame-received flag
// RL4 - a valid magic packet sets the magic-packet-received flag
// RL5 - wake-frame enable turns on wake-up frame detection through the filter
// RL6 - magic packet enable turns on magic packet wake mode
// RL7 - transmit checksum enable: zero bypasses the engine, one activates it
// RL8 - software changes transmit checksum enable only while transmit path is off
// RL9 - receive start mode: zero starts after 14 bytes, one at layer-3 header
// RL10 - software changes receive start mode only while receive path is off
// RL11 - receive checksum enable: zero bypasses the engine, one activates it
// RL12 - software changes receive checksum enable only while receive path is off
// RL13 - software never enables receive checksum and pad stripping together
// RL14 - filter loads through one indexed port, wraps after eight, resets to first
// RL15 - reserved bits read zero and writes to them do nothing
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "mwcc_cfg.svh"

module mwcc_top #(
    parameter int ADDR_W         = 8,
    parameter int FILTER_ENTRIES = 8
) (
    // clock and reset
    input  wire logic                       CLK_I,
    input  wire logic                       RESETN_I,
    input  wire logic                       SOFT_RESET_I,
    // axi4-lite write channels
    input  wire logic [ADDR_W-1:0]          S_AXI_AWADDR_I,
    input  wire logic                       S_AXI_AWVALID_I,
    output var  logic                       S_AXI_AWREADY_O,
    input  wire logic [31:0]                S_AXI_WDATA_I,
    input  wire logic [3:0]                 S_AXI_WSTRB_I,
    input  wire logic                       S_AXI_WVALID_I,
    output var  logic                       S_AXI_WREADY_O,
    output var  logic [1:0]                 S_AXI_BRESP_O,
    output var  logic                       S_AXI_BVALID_O,
    input  wire logic                       S_AXI_BREADY_I,
    // axi4-lite read channels
    input  wire logic [ADDR_W-1:0]          S_AXI_ARADDR_I,
    input  wire logic                       S_AXI_ARVALID_I,
    output var  logic                       S_AXI_ARREADY_O,
    output var  logic [31:0]                S_AXI_RDATA_O,
    output var  logic [1:0]                 S_AXI_RRESP_O,
    output var  logic                       S_AXI_RVALID_O,
    input  wire logic                       S_AXI_RREADY_I,
    // receive path
    input  wire mwcc_pkg::mwcc_rx_type      RX_I,
    input  wire logic                       POWER_SAVE_I,
    // wake and checksum controls
    output var  mwcc_pkg::mwcc_wake_mode_type WAKE_MODE_O,
    output var  logic                       WAKE_O,
    output var  mwcc_pkg::mwcc_csum_type    CSUM_O,
    output var  logic [FILTER_ENTRIES*32-1:0] WAKE_FILTER_O,
    // interrupt
    output var  logic                       IRQ_O
);
    import mwcc_pkg::*;

    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_bad_param
        $error("mwcc_top: ADDR_W must be 8 to 32");
    end

    mwcc_wr_state_type      wr_state_r;
    logic                   aw_held_r;
    logic                   w_held_r;
    logic [ADDR_W-1:0]      awaddr_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rdata_r;
    logic [29:0]            rd_idx_r;
    logic                   gue_r;
    logic                   wen_r;
    logic                   mpe_r;
    logic                   wfr_r;
    logic                   mpr_r;
    logic                   tx_en_r;
    logic                   rx_en_r;
    logic                   l3_mode_r;
    logic [`MWCC_IRQ_W-1:0] irq_stat_r;
    logic [`MWCC_IRQ_W-1:0] irq_mask_r;
    logic [`MWCC_IRQ_W-1:0] irq_set;
    mwcc_csum_type          csum_r;
    logic                   wake_r;
    logic                   wr_go;
    logic [29:0]            wr_idx;
    logic [29:0]            ar_idx;
    logic [31:0]            wm;
    logic [31:0]            wbits;
    logic                   wr_wake;
    logic                   wr_csum;
    logic                   wr_stat;
    logic                   wr_mask;
    logic                   wr_filt;
    logic                   wr_mapped;
    logic                   ar_go;
    logic [31:0]            rd_val;
    logic                   rd_mapped;
    logic                   rx_ok;
    logic                   uni_hit;
    logic                   wf_hit;
    logic                   mp_hit;

    ////////////////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order, answer after both
    assign S_AXI_AWREADY_O = (wr_state_r == MWCC_WR_IDLE) && !aw_held_r;
    assign S_AXI_WREADY_O  = (wr_state_r == MWCC_WR_IDLE) && !w_held_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;

    assign wr_go     = (wr_state_r == MWCC_WR_IDLE) && aw_held_r && w_held_r;
    assign wr_idx    = mwcc_word_idx(32'(awaddr_r));
    assign wm        = mwcc_strb_mask(wstrb_r);
    assign wbits     = wdata_r & wm;
    assign wr_wake   = wr_go && (wr_idx == 30'(`MWCC_IDX_WAKE));
    assign wr_csum   = wr_go && (wr_idx == 30'(`MWCC_IDX_CSUM));
    assign wr_stat   = wr_go && (wr_idx == 30'(`MWCC_IDX_IRQ_STAT));
    assign wr_mask   = wr_go && (wr_idx == 30'(`MWCC_IDX_IRQ_MASK));
    assign wr_filt   = wr_go && (wr_idx == 30'(`MWCC_IDX_FILTER));
    assign wr_mapped = wr_wake || wr_csum || wr_stat || wr_mask || wr_filt;

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            wr_state_r <= MWCC_WR_IDLE;
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            awaddr_r   <= '0;
            wdata_r    <= `MWCC_RST_WORD;
            wstrb_r    <= 4'h0;
            bvalid_r   <= 1'b0;
            bresp_r    <= `MWCC_RESP_OKAY;
        end
        else
        begin
            case (wr_state_r)
                MWCC_WR_IDLE:
                begin
                    if (S_AXI_AWVALID_I && !aw_held_r)
                    begin
                        aw_held_r <= 1'b1;
                        awaddr_r  <= S_AXI_AWADDR_I;
                    end
                    if (S_AXI_WVALID_I && !w_held_r)
                    begin
                        w_held_r <= 1'b1;
                        wdata_r  <= S_AXI_WDATA_I;
                        wstrb_r  <= S_AXI_WSTRB_I;
                    end
                    if (wr_go)
                    begin
                        wr_state_r <= MWCC_WR_RESP;
                        bvalid_r   <= 1'b1;
                        bresp_r    <= wr_mapped ? `MWCC_RESP_OKAY : `MWCC_RESP_SLVERR;
                    end
                end
                MWCC_WR_RESP:
                begin
                    if (S_AXI_BREADY_I)
                    begin
                        wr_state_r <= MWCC_WR_IDLE;
                        bvalid_r   <= 1'b0;
                        aw_held_r  <= 1'b0;
                        w_held_r   <= 1'b0;
                    end
                end
                default:
                begin
                    wr_state_r <= MWCC_WR_IDLE;
                    bvalid_r   <= 1'b0;
                    aw_held_r  <= 1'b0;
                    w_held_r   <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channels
    assign ar_idx          = mwcc_word_idx(32'(S_AXI_ARADDR_I));
    assign ar_go           = S_AXI_ARVALID_I && !rvalid_r;
    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RDATA_O   = rdata_r;
    assign S_AXI_RRESP_O   = rresp_r;

    always_comb
    begin
        rd_val    = `MWCC_RST_WORD;
        rd_mapped = 1'b1;
        if (ar_idx == 30'(`MWCC_IDX_WAKE))
        begin
            rd_val[`MWCC_WK_GUE] = gue_r; // RL15
            rd_val[`MWCC_WK_WFR] = wfr_r;
            rd_val[`MWCC_WK_MPR] = mpr_r;
            rd_val[`MWCC_WK_WEN] = wen_r;
            rd_val[`MWCC_WK_MPE] = mpe_r;
        end
        else if (ar_idx == 30'(`MWCC_IDX_CSUM))
        begin
            rd_val[`MWCC_CS_TXEN] = tx_en_r; // RL15
            rd_val[`MWCC_CS_MODE] = l3_mode_r;
            rd_val[`MWCC_CS_RXEN] = rx_en_r;
        end
        else if (ar_idx == 30'(`MWCC_IDX_IRQ_STAT))
            rd_val = 32'(irq_stat_r);
        else if (ar_idx == 30'(`MWCC_IDX_IRQ_MASK))
            rd_val = 32'(irq_mask_r);
        else if (ar_idx != 30'(`MWCC_IDX_FILTER))
            rd_mapped = 1'b0;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= `MWCC_RESP_OKAY;
            rdata_r  <= `MWCC_RST_WORD;
            rd_idx_r <= '0;
        end
        else if (ar_go)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_mapped ? `MWCC_RESP_OKAY : `MWCC_RESP_SLVERR;
            rdata_r  <= rd_val;
            rd_idx_r <= ar_idx;
        end
        else if (S_AXI_RREADY_I)
            rvalid_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake event detection
    assign rx_ok   = RX_I.frame_done && RX_I.frame_ok;
    assign uni_hit = rx_ok && gue_r && !RX_I.dest_addr[0]; // RL1 RL2
    assign wf_hit  = rx_ok && wen_r && RX_I.wake_match; // RL3 RL5
    assign mp_hit  = rx_ok && mpe_r && RX_I.magic_match; // RL4 RL6

    assign WAKE_MODE_O.global_unicast_wake_enable = gue_r;
    assign WAKE_MODE_O.wake_frame_enable          = wen_r; // RL5
    assign WAKE_MODE_O.magic_packet_enable        = mpe_r; // RL6
    assign WAKE_O                                 = wake_r;

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            wake_r <= 1'b0;
        else
            wake_r <= POWER_SAVE_I && (uni_hit || wf_hit || mp_hit); // RL1
    end

    // wake control bits; reserved bits are never stored
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            gue_r <= 1'b0;
            wen_r <= 1'b0;
            mpe_r <= 1'b0;
        end
        else if (wr_wake)
        begin
            if (wm[`MWCC_WK_GUE])
                gue_r <= wdata_r[`MWCC_WK_GUE];
            if (wm[`MWCC_WK_WEN])
                wen_r <= wdata_r[`MWCC_WK_WEN];
            if (wm[`MWCC_WK_MPE])
                mpe_r <= wdata_r[`MWCC_WK_MPE];
        end
    end

    // received flags: hardware set wins over write-one clear
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            wfr_r <= 1'b0;
            mpr_r <= 1'b0;
        end
        else
        begin
            wfr_r <= wf_hit || (wfr_r && !(wr_wake && wbits[`MWCC_WK_WFR])); // RL3
            mpr_r <= mp_hit || (mpr_r && !(wr_wake && wbits[`MWCC_WK_MPR])); // RL4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checksum offload control, relies on software changing it only while paths are off
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            tx_en_r   <= 1'b0;
            rx_en_r   <= 1'b0;
            l3_mode_r <= 1'b0;
        end
        else if (wr_csum)
        begin
            if (wm[`MWCC_CS_TXEN])
                tx_en_r <= wdata_r[`MWCC_CS_TXEN]; // RL7 RL8
            if (wm[`MWCC_CS_MODE])
                l3_mode_r <= wdata_r[`MWCC_CS_MODE]; // RL9 RL10
            if (wm[`MWCC_CS_RXEN])
                rx_en_r <= wdata_r[`MWCC_CS_RXEN]; // RL11 RL12
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            csum_r <= '0;
        else
        begin
            csum_r.tx_enable     <= tx_en_r; // RL7
            csum_r.rx_enable     <= rx_en_r; // RL11
            csum_r.rx_l3_mode    <= l3_mode_r;
            csum_r.rx_start_byte <= l3_mode_r ? mwcc_l3_start(RX_I.vlan_tags, RX_I.snap)
                                              : `MWCC_ETH_HDR_BYTES; // RL9
        end
    end

    assign CSUM_O = csum_r;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    always_comb
    begin
        irq_set               = '0;
        irq_set[`MWCC_IRQ_WFR] = wf_hit;
        irq_set[`MWCC_IRQ_MPR] = mp_hit;
        irq_set[`MWCC_IRQ_UNI] = uni_hit;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            irq_stat_r <= `MWCC_RST_IRQ;
            irq_mask_r <= `MWCC_RST_IRQ;
        end
        else
        begin
            irq_stat_r <= irq_set | (irq_stat_r & ~(wr_stat ? wbits[`MWCC_IRQ_W-1:0] : `MWCC_RST_IRQ));
            if (wr_mask)
                irq_mask_r <= (irq_mask_r & ~wm[`MWCC_IRQ_W-1:0]) | wbits[`MWCC_IRQ_W-1:0];
        end
    end

    assign IRQ_O = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // wake frame filter store
    mwcc_filter #(
        .ENTRIES (FILTER_ENTRIES),
        .W       (32)
    ) u_filter (
        .clk_i        (CLK_I),
        .resetn_i     (RESETN_I),
        .soft_reset_i (SOFT_RESET_I),
        .wr_i         (wr_filt), // RL14
        .wdata_i      (wdata_r),
        .wstrb_i      (wstrb_r),
        .entries_o    (WAKE_FILTER_O)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence csum_write_s(int bitpos);
        wr_csum && wm[bitpos];
    endsequence

    unicast_wake_a : assert property (POWER_SAVE_I && gue_r && rx_ok && !RX_I.dest_addr[0] |=> WAKE_O) // RL1
        else $error("global unicast frame did not wake");
    unicast_class_a : assert property (rx_ok && RX_I.dest_addr[0] && !wf_hit && !mp_hit |=> !WAKE_O) // RL2
        else $error("group address frame caused a wake");
    wake_flag_a : assert property (wf_hit |=> wfr_r && irq_stat_r[`MWCC_IRQ_WFR]) // RL3
        else $error("wake frame flag not set");
    magic_flag_a : assert property (mp_hit |=> mpr_r && irq_stat_r[`MWCC_IRQ_MPR]) // RL4
        else $error("magic packet flag not set");
    wake_gate_a : assert property (!wen_r && !wfr_r |=> !wfr_r) // RL5
        else $error("wake frame flag set while detection off");
    magic_gate_a : assert property (!mpe_r && !mpr_r |=> !mpr_r) // RL6
        else $error("magic flag set while detection off");
    tx_engine_a : assert property (csum_write_s(`MWCC_CS_TXEN) // RL7
        |=> tx_en_r == $past(wdata_r[`MWCC_CS_TXEN]) ##1 CSUM_O.tx_enable == $past(wdata_r[`MWCC_CS_TXEN], 2))
        else $error("transmit checksum enable not applied");
    rx_start_a : assert property (!l3_mode_r |=> CSUM_O.rx_start_byte == `MWCC_ETH_HDR_BYTES) // RL9
        else $error("fixed receive checksum start wrong");
    rx_vlan_a : assert property (l3_mode_r && RX_I.vlan_tags == 2'h1 && !RX_I.snap // RL9
        |=> CSUM_O.rx_start_byte == 8'(`MWCC_ETH_HDR_BYTES + `MWCC_VLAN_BYTES))
        else $error("layer-3 receive checksum start wrong");
    rx_engine_a : assert property (csum_write_s(`MWCC_CS_RXEN) // RL11
        |=> rx_en_r == $past(wdata_r[`MWCC_CS_RXEN]) ##1 CSUM_O.rx_enable == $past(wdata_r[`MWCC_CS_RXEN], 2))
        else $error("receive checksum enable not applied");
    wake_reserved_a : assert property (rvalid_r && rd_idx_r == 30'(`MWCC_IDX_WAKE) // RL15
        |-> (rdata_r & ~`MWCC_WK_ALL_MASK) == 32'h0)
        else $error("wake register reserved bits not zero");
    csum_reserved_a : assert property (rvalid_r && rd_idx_r == 30'(`MWCC_IDX_CSUM) // RL15
        |-> (rdata_r & ~`MWCC_CS_ALL_MASK) == 32'h0)
        else $error("checksum register reserved bits not zero");

endmodule // mwcc_top

`default_nettype wire

// ### tb.sv
// self-checking bench of the wake and checksum control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mwcc_pkg::*;
    logic clk = 0, rst_n = 0, srst = 0, ps = 1;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rd;
    logic [3:0] ws = 4'hf;
    logic awr, wr_, bv, arr, rv, wk, irq;
    logic [1:0] br, rr;
    mwcc_rx_type rx = '0;
    mwcc_wake_mode_type wm;
    mwcc_csum_type cs;
    logic [255:0] flt;
    int bad_count = 0, checked = 0, cyc = 0;
    always #20 clk = ~clk;
    mwcc_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .SOFT_RESET_I(srst), .S_AXI_AWADDR_I(aw),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
        .RX_I(rx), .POWER_SAVE_I(ps), .WAKE_MODE_O(wm), .WAKE_O(wk), .CSUM_O(cs),
        .WAKE_FILTER_O(flt), .IRQ_O(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            finish_test;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        aw <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr_) wv <= 0;
        end
        while ((awv && !awr) || (wv && !wr_));
        do @(posedge clk); while (!bv);
        chk(br, er);
        bry <= 0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ar <= a; arv <= 1; rry <= 1;
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
        rry <= 0;
        chk(rd, e);
        chk(rr, er);
        @(posedge clk);
    endtask
    task automatic frame(input logic d0, input logic m1, input logic m2, input logic e);
        rx.frame_done <= 1; rx.frame_ok <= 1; rx.dest_addr <= {47'h0, d0};
        rx.wake_match <= m1; rx.magic_match <= m2;
        @(posedge clk) rx.frame_done <= 0;
        @(posedge clk) chk(wk, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        @(posedge clk);
        rdc(8'h30, 32'h0, 2'h0);
        rdc(8'h34, 32'h0, 2'h0);
        wr(8'h3c, 32'hffff_ffff, 2'h2);
        rdc(8'h3c, 32'h0, 2'h2);
        wr(8'h30, 32'hffff_ffff);
        rdc(8'h30, 32'h0000_0206, 2'h0);
        chk(wm, 3'h7);
        rx.vlan_tags <= 2'h2; rx.snap <= 1;
        wr(8'h34, 32'hffff_ffff);
        rdc(8'h34, 32'h0001_0003, 2'h0);
        chk(cs, {3'h7, 8'h1e});
        rx.vlan_tags <= 2'h1; rx.snap <= 0;
        repeat (2) @(posedge clk);
        chk(cs, {3'h7, 8'h12});
        wr(8'h34, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(cs, {3'h2, 8'h0e});
        $display("register test done");
    endtask
    task automatic t_wake;
        wr(8'h44, 32'h7);
        frame(0, 0, 0, 1);
        frame(1, 0, 0, 0);
        frame(1, 1, 0, 1);
        rdc(8'h30, 32'h0000_0246, 2'h0);
        frame(1, 0, 1, 1);
        rdc(8'h30, 32'h0000_0266, 2'h0);
        wr(8'h30, 32'h0000_0266);
        rdc(8'h30, 32'h0000_0206, 2'h0);
        chk(irq, 1);
        rdc(8'h40, 32'h7, 2'h0);
        rdc(8'h44, 32'h7, 2'h0);
        wr(8'h40, 32'h7);
        chk(irq, 0);
        wr(8'h30, 32'h0000_0200);
        frame(1, 1, 1, 0);
        rdc(8'h30, 32'h0000_0200, 2'h0);
        ps <= 0;
        frame(0, 0, 0, 0);
        rdc(8'h40, 32'h4, 2'h0);
        $display("wake test done");
    endtask
    task automatic t_filter;
        for (int i = 0; i < 9; i++) wr(8'h2c, 32'(i));
        chk(flt[31:0], 32'h8);
        chk(flt[63:32], 32'h1);
        wr(8'h2c, 32'haa);
        srst <= 1;
        @(posedge clk) srst <= 0;
        wr(8'h2c, 32'hbb);
        chk(flt[63:32], 32'haa);
        chk(flt[31:0], 32'hbb);
        rdc(8'h2c, 32'h0, 2'h0);
        $display("filter test done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        t_regs;
        t_wake;
        t_filter;
        finish_test;
    end
endmodule // tb
`default_nettype wire
